// ---- design/ser_cfg_map.vh ----
/*
  Register map, field positions, reset values and timing counts of the
  serializer configuration register bank.
  Assumes a 10 MHz core clock; included by the design files by bare name.
*/
// Operation
// - Failsafe bit picks idle level of undriven inputs: 1 low, 0 high; resets 1.
// - While error-count-clear bit is 1, CRC error counters are held at zero.
// - Compat-source bit 1 takes compatibility from register, 0 from mode pin.
// - Under register control, compatibility bit 1 enables legacy mode; default 0.
// - Range-source bit 1 takes pixel-clock range from register, 0 from mode pin.
// - Under register control, low-frequency bit 1 selects 5 to 15 MHz range.
// - Two-bit field delays SDA after SCL: 240, 280, 320, 360 ns.
// - Local-write-disable rejects register writes from the remote I2C master.
// - Local-write-disable leaves remote accesses to other local slaves untouched.
// - Watchdog expires after about 50 ms with speed-up, else about 1 s.
// - A control bit turns the watchdog off; no idle or hang detection then.
// - SDA high and idle for the timeout marks the bus free.
// - SDA low and idle until expiry makes the device drive 9 SCL pulses.
// - Error status flag clears on link loss or while error-count-clear is set.
// - CRC error count is 16 bits, read as low and high bytes.
`ifndef SER_CFG_MAP_VH
`define SER_CFG_MAP_VH
`define CFG_OFS 8'h04
`define I2C_OFS 8'h05
`define CRC_LO_OFS 8'h0a
`define CRC_HI_OFS 8'h0b
`define STAT_OFS 8'h0c
`define CFG_RST 8'h80
`define I2C_RST 8'h00
`define CFG_MASK 8'haf
`define I2C_MASK 8'h1f
`define B_FAILSAFE 7
`define B_CRC_CLR 5
`define B_COMPAT_SRC 3
`define B_COMPAT 2
`define B_LFREQ_SRC 1
`define B_LFREQ 0
`define B_LWD 2
`define B_WD_FAST 1
`define B_WD_OFF 0
`define STAT_ERR_BIT 1
`define CLK_NS 100
`define SYNC_CYC 2
`define SDA_DLY_BASE_NS 240
`define SDA_DLY_STEP_NS 40
`define WD_FAST_MS 50
`define WD_SLOW_MS 1000
`define NS_PER_MS 1000000
`define RECOV_PULSES 9
`define RECOV_HALF_NS 5000
`endif

// ---- design/i2c_bus_watchdog.v ----
/*
  I2C bus watchdog: marks the bus free after a quiet high SDA and clears
  a hung bus with clock pulses on SCL.
  Assumes synchronised bus levels and an activity pulse from the same clock.
*/
`timescale 1ns/10ps
`include "ser_cfg_map.vh"
module i2c_bus_watchdog #(
  parameter [31:0] FAST_CYC = 32'd500000,
  parameter [31:0] SLOW_CYC = 32'd10000000,
  parameter [31:0] HALF_CYC = 32'd50
)(
  input wire clk,
  input wire rst_n,
  input wire activity,
  input wire sda_lvl,
  input wire wd_off,
  input wire speedup,
  output reg bus_free,
  output reg scl_pull
);
  localparam W_MON = 3'b001;
  localparam W_PULL = 3'b010;
  localparam W_REL = 3'b100;
  reg [2:0] st_r;
  reg [23:0] idle_r;
  reg [15:0] half_r;
  reg [3:0] pulse_r;
  wire [23:0] lim;
  wire half_done;
  assign lim = speedup ? FAST_CYC[23:0] : SLOW_CYC[23:0];
  assign half_done = (half_r == HALF_CYC[15:0] - 16'h0001);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= W_MON;
      idle_r <= 24'h000000;
      half_r <= 16'h0000;
      pulse_r <= 4'h0;
      bus_free <= 1'b0;
      scl_pull <= 1'b0;
    end
    else if (wd_off)
    begin
      st_r <= W_MON;
      idle_r <= 24'h000000;
      bus_free <= 1'b0;
      scl_pull <= 1'b0;
    end
    else
    begin
      case (st_r)
        W_MON:
        begin
          if (activity)
          begin
            idle_r <= 24'h000000;
            bus_free <= 1'b0;
          end
          else if (idle_r >= lim - 24'h000001)
          begin
            if (sda_lvl)
              bus_free <= 1'b1;
            else
            begin
              st_r <= W_PULL;
              idle_r <= 24'h000000;
              half_r <= 16'h0000;
              pulse_r <= 4'h0;
              scl_pull <= 1'b1;
            end
          end
          else
            idle_r <= idle_r + 24'h000001;
        end
        W_PULL:
        begin
          half_r <= half_done ? 16'h0000 : half_r + 16'h0001;
          if (half_done)
          begin
            st_r <= W_REL;
            scl_pull <= 1'b0;
          end
        end
        W_REL:
        begin
          half_r <= half_done ? 16'h0000 : half_r + 16'h0001;
          if (half_done)
          begin
            if (pulse_r == `RECOV_PULSES - 1)
              st_r <= W_MON;
            else
            begin
              pulse_r <= pulse_r + 4'h1;
              st_r <= W_PULL;
              scl_pull <= 1'b1;
            end
          end
        end
        default:
          st_r <= W_MON;
      endcase
    end
  end
endmodule

// ---- design/ser_cfg_regs.v ----
/*
  Serializer configuration registers behind an I2C slave port: failsafe,
  legacy compatibility, pixel-clock range, SDA delay, remote write lock,
  CRC error counter and the bus watchdog.
  Assumes open-drain SCL and SDA resolved outside, and side signals for
  remote traffic, CRC errors and link loss from logic on REF_CLK_IN.
*/
`timescale 1ns/10ps
`include "ser_cfg_map.vh"
module ser_cfg_regs #(
  parameter [6:0] DEV_ADDR = 7'h2a,
  parameter [31:0] WD_FAST_CYC = `WD_FAST_MS * (`NS_PER_MS / `CLK_NS),
  parameter [31:0] WD_SLOW_CYC = `WD_SLOW_MS * (`NS_PER_MS / `CLK_NS),
  parameter [31:0] RECOV_HALF_CYC = `RECOV_HALF_NS / `CLK_NS
)(
  input wire REF_CLK_IN,
  input wire ARST_N_IN,
  input wire SCL_IN,
  output wire SCL_OUT,
  output wire SCL_OE_OUT,
  input wire SDA_IN,
  output wire SDA_OUT,
  output reg SDA_OE_OUT,
  input wire MODE_SEL_COMPAT_IN,
  input wire MODE_SEL_LFREQ_IN,
  input wire REMOTE_ACCESS_IN,
  input wire CRC_ERR_IN,
  input wire LINK_LOST_IN,
  output reg FAILSAFE_LOW_OUT,
  output reg LEGACY_LINK_COMPAT_OUT,
  output reg LOW_FREQ_RANGE_BIT_OUT,
  output reg CRC_ERR_FLAG_OUT,
  output wire BUS_FREE_OUT
);
  localparam ST_IDLE = 7'b0000001;
  localparam ST_ADDR = 7'b0000010;
  localparam ST_AACK = 7'b0000100;
  localparam ST_WR = 7'b0001000;
  localparam ST_WACK = 7'b0010000;
  localparam ST_RD = 7'b0100000;
  localparam ST_RACK = 7'b1000000;

  reg [1:0] rst_sync_r;
  wire rst_n;
  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg [1:0] msc_s_r;
  reg [1:0] msl_s_r;
  reg [6:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg first_r;
  reg nak_r;
  reg want_r;
  reg [2:0] dly_r;
  reg [7:0] cfg_r;
  reg [7:0] i2c_r;
  reg [15:0] crc_cnt_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire activity;
  wire [7:0] rd_val;
  wire [2:0] sda_dly;
  wire wd_pull;
  wire wr_ok;

  // Delay from the detected edge; the synchroniser already adds two cycles
  function [2:0] dly_cyc;
    input [1:0] code;
    integer t;
    begin
      t = (`SDA_DLY_BASE_NS + `SDA_DLY_STEP_NS * code + `CLK_NS - 1) / `CLK_NS - `SYNC_CYC;
      if (t < 1)
        t = 1;
      dly_cyc = t[2:0];
    end
  endfunction

  function [7:0] rd_mux;
    input [7:0] a;
    input [7:0] cfg;
    input [7:0] ctl;
    input [15:0] cnt;
    input err;
    begin
      case (a)
        `CFG_OFS: rd_mux = cfg;
        `I2C_OFS: rd_mux = ctl;
        `CRC_LO_OFS: rd_mux = cnt[7:0];
        `CRC_HI_OFS: rd_mux = cnt[15:8];
        `STAT_OFS: rd_mux = {6'h00, err, 1'b0};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  always @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pins pass two flops; the third stage only feeds edge detection
  always @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_r <= 3'b111;
      sda_s_r <= 3'b111;
      msc_s_r <= 2'b00;
      msl_s_r <= 2'b00;
    end
    else
    begin
      scl_s_r <= {scl_s_r[1:0], SCL_IN};
      sda_s_r <= {sda_s_r[1:0], SDA_IN};
      msc_s_r <= {msc_s_r[0], MODE_SEL_COMPAT_IN};
      msl_s_r <= {msl_s_r[0], MODE_SEL_LFREQ_IN};
    end
  end

  assign scl_rise = scl_s_r[1] & ~scl_s_r[2];
  assign scl_fall = ~scl_s_r[1] & scl_s_r[2];
  assign start_det = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
  assign stop_det = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];
  assign activity = (scl_s_r[1] ^ scl_s_r[2]) | (sda_s_r[1] ^ sda_s_r[2]);
  assign rd_val = rd_mux(ptr_r, cfg_r, i2c_r, crc_cnt_r, CRC_ERR_FLAG_OUT);
  assign sda_dly = dly_cyc(i2c_r[4:3]);
  assign wr_ok = ~(REMOTE_ACCESS_IN & i2c_r[`B_LWD]);

  // Slave protocol; SDA changes are queued and released after the delay, but start and stop release SDA at once
  always @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nak_r <= 1'b0;
      want_r <= 1'b0;
      dly_r <= 3'h0;
      SDA_OE_OUT <= 1'b0;
      cfg_r <= `CFG_RST;
      i2c_r <= `I2C_RST;
    end
    else
    begin
      if (dly_r != 3'h0)
      begin
        dly_r <= dly_r - 3'h1;
        if (dly_r == 3'h1)
          SDA_OE_OUT <= want_r;
      end
      if (start_det)
      begin
        st_r <= ST_ADDR;
        cnt_r <= 4'h0;
        want_r <= 1'b0;
        dly_r <= 3'h0;
        SDA_OE_OUT <= 1'b0;
      end
      else if (stop_det)
      begin
        st_r <= ST_IDLE;
        want_r <= 1'b0;
        dly_r <= 3'h0;
        SDA_OE_OUT <= 1'b0;
      end
      else
      begin
        case (st_r)
          ST_IDLE:
            st_r <= ST_IDLE;
          ST_ADDR, ST_WR:
          begin
            if (scl_rise)
            begin
              sh_r <= {sh_r[6:0], sda_s_r[1]};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (scl_fall && cnt_r == 4'h8)
            begin
              if (st_r == ST_WR)
              begin
                st_r <= ST_WACK;
                want_r <= 1'b1;
                dly_r <= sda_dly;
                first_r <= 1'b0;
                if (first_r)
                  ptr_r <= sh_r;
                else
                begin
                  ptr_r <= ptr_r + 8'h01;
                  if (wr_ok && ptr_r == `CFG_OFS)
                    cfg_r <= sh_r & `CFG_MASK;
                  if (wr_ok && ptr_r == `I2C_OFS)
                    i2c_r <= sh_r & `I2C_MASK;
                end
              end
              else if (sh_r[7:1] == DEV_ADDR)
              begin
                st_r <= ST_AACK;
                rw_r <= sh_r[0];
                want_r <= 1'b1;
                dly_r <= sda_dly;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          ST_AACK, ST_WACK:
          begin
            if (scl_fall)
            begin
              cnt_r <= 4'h0;
              dly_r <= sda_dly;
              if (st_r == ST_AACK && rw_r)
              begin
                st_r <= ST_RD;
                want_r <= ~rd_val[7];
                sh_r <= {rd_val[6:0], 1'b0};
              end
              else
              begin
                st_r <= ST_WR;
                want_r <= 1'b0;
                if (st_r == ST_AACK)
                  first_r <= 1'b1;
              end
            end
          end
          ST_RD:
          begin
            if (scl_rise)
              cnt_r <= cnt_r + 4'h1;
            else if (scl_fall)
            begin
              dly_r <= sda_dly;
              if (cnt_r == 4'h8)
              begin
                st_r <= ST_RACK;
                want_r <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
              end
              else
              begin
                want_r <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
              nak_r <= sda_s_r[1];
            else if (scl_fall)
            begin
              cnt_r <= 4'h0;
              if (nak_r)
                st_r <= ST_IDLE;
              else
              begin
                st_r <= ST_RD;
                want_r <= ~rd_val[7];
                dly_r <= sda_dly;
                sh_r <= {rd_val[6:0], 1'b0};
              end
            end
          end
          default:
            st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Error counter and flag; the clear bit is a level, so it outranks errors
  always @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_cnt_r <= 16'h0000;
      CRC_ERR_FLAG_OUT <= 1'b0;
    end
    else if (cfg_r[`B_CRC_CLR])
    begin
      crc_cnt_r <= 16'h0000;
      CRC_ERR_FLAG_OUT <= 1'b0;
    end
    else if (CRC_ERR_IN)
    begin
      // Saturates rather than wrapping to a misleading small count
      if (crc_cnt_r != 16'hffff)
        crc_cnt_r <= crc_cnt_r + 16'h0001;
      CRC_ERR_FLAG_OUT <= 1'b1;
    end
    else if (LINK_LOST_IN)
      CRC_ERR_FLAG_OUT <= 1'b0;
  end

  always @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      FAILSAFE_LOW_OUT <= 1'b1;
      LEGACY_LINK_COMPAT_OUT <= 1'b0;
      LOW_FREQ_RANGE_BIT_OUT <= 1'b0;
    end
    else
    begin
      FAILSAFE_LOW_OUT <= cfg_r[`B_FAILSAFE];
      LEGACY_LINK_COMPAT_OUT <= cfg_r[`B_COMPAT_SRC] ? cfg_r[`B_COMPAT] : msc_s_r[1];
      LOW_FREQ_RANGE_BIT_OUT <= cfg_r[`B_LFREQ_SRC] ? cfg_r[`B_LFREQ] : msl_s_r[1];
    end
  end

  i2c_bus_watchdog #(
    .FAST_CYC(WD_FAST_CYC),
    .SLOW_CYC(WD_SLOW_CYC),
    .HALF_CYC(RECOV_HALF_CYC)
  ) u_wd (
    .clk(REF_CLK_IN),
    .rst_n(rst_n),
    .activity(activity),
    .sda_lvl(sda_s_r[1]),
    .wd_off(i2c_r[`B_WD_OFF]),
    .speedup(i2c_r[`B_WD_FAST]),
    .bus_free(BUS_FREE_OUT),
    .scl_pull(wd_pull)
  );

  // Open drain: only ever pull low
  assign SCL_OUT = 1'b0;
  assign SCL_OE_OUT = wd_pull;
  assign SDA_OUT = 1'b0;
endmodule

// ---- testbench/i2c_host_model.sv ----
/*
  Host I2C master model on open-drain SCL and SDA, one bit per 800 ns.
  Assumes the bench resolves the wires with pull-ups; enable high pulls low.
*/
`timescale 1ns/10ps
module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  logic ack;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while SCL is low; long low phase covers the slave's slowest SDA delay
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_oe <= ~b;
    tick(3);
    scl_oe <= 1'b0;
    tick(2);
    r = sda;
    tick(1);
    scl_oe <= 1'b1;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  // Long setup so a late device release cannot race SCL
  task automatic start();
    tick(2);
    sda_oe <= 1'b0;
    tick(4);
    scl_oe <= 1'b0;
    tick(4);
    sda_oe <= 1'b1;
    tick(4);
    scl_oe <= 1'b1;
  endtask
  task automatic stop();
    tick(2);
    sda_oe <= 1'b1;
    tick(2);
    scl_oe <= 1'b0;
    tick(4);
    sda_oe <= 1'b0;
  endtask
  // Abandoned frame: SDA left low, SCL idle high
  task automatic hang();
    start();
    tick(4);
    scl_oe <= 1'b0;
  endtask
endmodule

// ---- testbench/ser_cfg_regs_assertions.sv ----
/*
  Port checker for ser_cfg_regs.
  Assumes the top ports only; bound below.
*/
`timescale 1ns/10ps
module ser_cfg_regs_assertions #(
  parameter [31:0] RECOV_HALF_CYC = 32'h32
)(
  input wire REF_CLK_IN,
  input wire ARST_N_IN,
  input wire SCL_IN,
  input wire SCL_OE_OUT,
  input wire SDA_IN,
  input wire SDA_OE_OUT,
  input wire CRC_ERR_IN,
  input wire LINK_LOST_IN,
  input wire FAILSAFE_LOW_OUT,
  input wire CRC_ERR_FLAG_OUT,
  input wire BUS_FREE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  reg [31:0] hi_cnt_r;
  // Length of each recovery pull
  always @(posedge REF_CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
      hi_cnt_r <= 32'h0;
    else
      hi_cnt_r <= SCL_OE_OUT ? hi_cnt_r + 32'h1 : 32'h0;
  property p_err_cause; $rose(CRC_ERR_FLAG_OUT) |-> $past(CRC_ERR_IN); endproperty
  a_err_cause: assert property (p_err_cause) else $error("flag rose without error");
  property p_link_clr; LINK_LOST_IN && !CRC_ERR_IN |=> !CRC_ERR_FLAG_OUT; endproperty
  a_link_clr: assert property (p_link_clr) else $error("flag kept on link loss");
  property p_pull_len; $fell(SCL_OE_OUT) |-> hi_cnt_r == RECOV_HALF_CYC; endproperty
  a_pull_len: assert property (p_pull_len) else $error("recovery pulse length");
  property p_free_drop; $changed(SDA_IN) || $changed(SCL_IN) |-> ##[1:4] !BUS_FREE_OUT; endproperty
  a_free_drop: assert property (p_free_drop) else $error("bus free during activity");
  property p_free_rise; $rose(BUS_FREE_OUT) |-> SDA_IN && $past(SDA_IN, 8) && $stable(SCL_IN); endproperty
  a_free_rise: assert property (p_free_rise) else $error("bus free without quiet high");
  property p_no_both; !(BUS_FREE_OUT && SCL_OE_OUT); endproperty
  a_no_both: assert property (p_no_both) else $error("recovery on free bus");
  property p_sda_dly; $rose(SDA_OE_OUT) |-> !$past(SCL_IN, 1) && !$past(SCL_IN, 4); endproperty
  a_sda_dly: assert property (p_sda_dly) else $error("SDA driven too early");
  property p_cfg_low; $changed(FAILSAFE_LOW_OUT) |-> !$past(SCL_IN, 2); endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("config changed off write");
  cover property ($rose(BUS_FREE_OUT));
  cover property ($rose(SCL_OE_OUT));
  cover property ($rose(CRC_ERR_FLAG_OUT));
endmodule
bind ser_cfg_regs ser_cfg_regs_assertions #(.RECOV_HALF_CYC(RECOV_HALF_CYC)) chk (.REF_CLK_IN(REF_CLK_IN),
  .ARST_N_IN(ARST_N_IN), .SCL_IN(SCL_IN), .SCL_OE_OUT(SCL_OE_OUT), .SDA_IN(SDA_IN), .SDA_OE_OUT(SDA_OE_OUT),
  .CRC_ERR_IN(CRC_ERR_IN), .LINK_LOST_IN(LINK_LOST_IN), .FAILSAFE_LOW_OUT(FAILSAFE_LOW_OUT),
  .CRC_ERR_FLAG_OUT(CRC_ERR_FLAG_OUT), .BUS_FREE_OUT(BUS_FREE_OUT));

// ---- testbench/tb_ser_cfg_regs.sv ----
/*
  Self-checking bench for ser_cfg_regs with shortened watchdog counts.
  Assumes i2c_host_model on the bus and pull-ups on SCL and SDA.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_ser_cfg_regs;
  localparam int WF = 32'hc8;
  localparam int WS = 32'h190;
  localparam int RH = 32'h4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cpin = 1'b0, lpin = 1'b0, remote = 1'b0, crc_err = 1'b0, link_lost = 1'b0;
  wire scl_oe, sda_oe, h_scl, h_sda, fs, bc, lf, flag, free, so, dout;
  // Pull-ups; the device's drive level only matters while it is enabled
  wire scl = (scl_oe ? so : 1'b1) && !h_scl;
  wire sda = (sda_oe ? dout : 1'b1) && !h_sda;
  int mismatches = 0, total_checks = 0, n, p, w;
  logic [31:0] seed = 32'h4, r;
  logic [7:0] q, v4, v5;
  logic prev;
  ser_cfg_regs #(.WD_FAST_CYC(WF), .WD_SLOW_CYC(WS), .RECOV_HALF_CYC(RH)) DUT (.REF_CLK_IN(clk),
    .ARST_N_IN(arst_n), .SCL_IN(scl), .SCL_OUT(so), .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(dout),
    .SDA_OE_OUT(sda_oe), .MODE_SEL_COMPAT_IN(cpin), .MODE_SEL_LFREQ_IN(lpin), .REMOTE_ACCESS_IN(remote),
    .CRC_ERR_IN(crc_err), .LINK_LOST_IN(link_lost), .FAILSAFE_LOW_OUT(fs), .LEGACY_LINK_COMPAT_OUT(bc),
    .LOW_FREQ_RANGE_BIT_OUT(lf), .CRC_ERR_FLAG_OUT(flag), .BUS_FREE_OUT(free));
  i2c_host_model host (.clk(clk), .sda(sda), .scl_oe(h_scl), .sda_oe(h_sda));
  always #50 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic pick(input logic src, input logic rb, input logic pin);
    return src ? rb : pin;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse(input bit lnk);
    if (lnk)
      link_lost <= 1'b1;
    else
      crc_err <= 1'b1;
    cyc(1);
    link_lost <= 1'b0;
    crc_err <= 1'b0;
    cyc(1);
  endtask
  // One transfer writes both configuration registers
  task automatic wr(input logic [7:0] d4, input logic [7:0] d5);
    host.start();
    host.xfer(8'h54, q);
    host.xfer(8'h04, q);
    host.xfer(d4, q);
    host.xfer(d5, q);
    host.stop();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.start();
    host.xfer(8'h54, q);
    host.xfer(a, q);
    host.start();
    host.xfer(8'h55, q);
    host.xfer(8'hff, q);
    host.stop();
    `CHK(q, e)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #5000000;
    mismatches++;
    final_report();
  end
  initial
  begin
    cyc(6);
    arst_n <= 1'b1;
    cyc(6);
    rchk(8'h04, 8'h80);
    rchk(8'h05, 8'h00);
    rchk(8'h30, 8'h00);
    `CHK(fs, 1'b1)
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      r = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : rnd();
      v4 = r[7:0];
      v5 = r[15:8];
      cpin <= r[16];
      lpin <= r[17];
      wr(v4, v5);
      cyc(4);
      `CHK(fs, v4[7])
      `CHK(bc, pick(v4[3], v4[2], r[16]))
      `CHK(lf, pick(v4[1], v4[0], r[17]))
      rchk(8'h04, v4 & 8'haf);
      rchk(8'h05, v5 & 8'h1f);
    end
    $display("config test done");
    wr(8'h80, 8'h00);
    repeat (3) pulse(1'b0);
    `CHK(flag, 1'b1)
    rchk(8'h0c, 8'h02);
    rchk(8'h0a, 8'h03);
    pulse(1'b1);
    `CHK(flag, 1'b0)
    pulse(1'b0);
    wr(8'ha0, 8'h00);
    pulse(1'b0);
    `CHK(flag, 1'b0)
    rchk(8'h0a, 8'h00);
    wr(8'h80, 8'h00);
    repeat (257) pulse(1'b0);
    rchk(8'h0a, 8'h01);
    rchk(8'h0b, 8'h01);
    $display("error count test done");
    wr(8'h80, 8'h04);
    remote <= 1'b1;
    wr(8'h01, 8'h00);
    // Foreign slave address: left alone, no acknowledge
    host.start();
    host.xfer(8'h56, q);
    `CHK(host.ack, 1'b0)
    host.stop();
    rchk(8'h04, 8'h80);
    rchk(8'h05, 8'h04);
    remote <= 1'b0;
    wr(8'h01, 8'h00);
    rchk(8'h04, 8'h01);
    $display("write lock test done");
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h80, (k == 0) ? 8'h02 : (k == 1) ? 8'h00 : 8'h03);
      w = (k == 0) ? WF : WS;
      n = 0;
      while (free !== 1'b1 && n < 1000)
      begin
        cyc(1);
        n++;
      end
      // Off: never free within the long timeout
      `CHK((k == 2) ? (n == 1000) : (n >= w && n <= w + 10), 1'b1)
    end
    wr(8'h80, 8'h02);
    host.hang();
    n = 0;
    while (scl_oe !== 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    `CHK(n >= WF && n <= WF + 10, 1'b1)
    p = 1;
    for (int j = 0; j < 18 * RH + 20; j++)
    begin
      prev = scl_oe;
      cyc(1);
      p += (scl_oe === 1'b1 && prev === 1'b0) ? 1 : 0;
    end
    `CHK(p, 32'h9)
    host.stop();
    $display("watchdog test done");
    final_report();
  end
endmodule
